// [rtl/see_pkg.sv]
package see_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  localparam logic [7:0] CMD_MASK = 8'hF7;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STAT = 8'h05;
  localparam logic [7:0] STAT_BUSY = 8'hFF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] ADDR_LAST = 4'hF;
  localparam logic [1:0] HDR_ADDR = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 5_000_000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_NS = 100;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    DS_IDLE = 6'h01,
    DS_CMD = 6'h02,
    DS_ADDR = 6'h04,
    DS_RDATA = 6'h08,
    DS_WDATA = 6'h10,
    DS_IGNORE = 6'h20
  } see_dev_st_t;

  typedef struct packed {
    see_dev_st_t st;
    logic cs_s1;
    logic cs_s2;
    logic cs_q;
    logic sck_s1;
    logic sck_s2;
    logic sck_q;
    logic si_s1;
    logic si_s2;
    logic [15:0] sh;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic is_rd;
    logic is_stat;
    logic [7:0] tx;
    logic so;
    logic so_oe;
    logic wel;
    logic busy;
    logic [31:0] wcnt;
    logic byte_ok;
    logic [PAGE_BYTES-1:0] pvalid;
  } see_dev_s_t;

  localparam see_dev_s_t DEV_RST = '{st: DS_IDLE, cs_s1: 1'b1, cs_s2: 1'b1, cs_q: 1'b1,
                                      default: '0};

  typedef enum logic [2:0] {
    HOP_WR_ENABLE = 3'h0,
    HOP_WRDI = 3'h1,
    HOP_STAT = 3'h2,
    HOP_READ = 3'h3,
    HOP_WRITE = 3'h4
  } see_host_op_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SHIFT = 4'h2,
    HS_TAIL = 4'h4,
    HS_GAP = 4'h8
  } see_host_st_t;

  typedef struct packed {
    see_host_st_t st;
    see_host_op_t op;
    logic [15:0] addr;
    logic [16:0] left;
    logic [1:0] hdr;
    logic cur_data;
    logic [7:0] div;
    logic [2:0] bitc;
    logic [7:0] tx;
    logic [7:0] rx;
    logic so_s1;
    logic so_s2;
    logic cs_n;
    logic sck;
    logic si;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_take;
    logic busy;
    logic done;
  } see_host_s_t;

  localparam see_host_s_t HOST_RST = '{st: HS_IDLE, op: HOP_WR_ENABLE, cs_n: 1'b1, default: '0};
endpackage : see_pkg

// [rtl/see_link_if.sv]
`timescale 1ns/10ps
interface see_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;

  modport dev (
    input cs_n,
    input sck,
    input si,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input so,
    input so_oe
  );
endinterface : see_link_if

// [rtl/see_host.sv]
`timescale 1ns/10ps
module see_host
  import see_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  see_link_if.host link,
  input wire logic req_in,
  input wire see_host_op_t op_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] len_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic wr_take_out,
  output logic busy_out,
  output logic done_out
);
  see_host_s_t s_ff;
  see_host_s_t nxt_s;
  logic half;
  logic [7:0] nb;
  logic [7:0] opc;

  always_comb begin
    nxt_s = s_ff;
    nb = 8'h00;
    opc = OP_WR_ENABLE;
    half = s_ff.div == 8'(SCK_HALF_CYCLES - 1);
    nxt_s.so_s1 = link.so;
    nxt_s.so_s2 = s_ff.so_s1;
    nxt_s.rd_valid = 1'b0;
    nxt_s.wr_take = 1'b0;
    nxt_s.done = 1'b0;
    nxt_s.div = half ? 8'h00 : s_ff.div + 8'h01;
    case (op_in)
      HOP_WRDI: opc = OP_WRDI;
      HOP_STAT: opc = OP_STAT;
      HOP_READ: opc = OP_READ;
      HOP_WRITE: opc = OP_WRITE;
      default: opc = OP_WR_ENABLE;
    endcase
    case (s_ff.st)
      HS_IDLE: begin
        nxt_s.div = 8'h00;
        if (req_in) begin
          // Frame opens on a fresh select edge, command first, MSB first
          nxt_s.op = op_in;
          nxt_s.addr = addr_in;
          nxt_s.cs_n = 1'b0;
          nxt_s.sck = 1'b0;
          nxt_s.si = opc[7];
          nxt_s.tx = {opc[6:0], 1'b0};
          nxt_s.bitc = 3'h0;
          nxt_s.cur_data = 1'b0;
          nxt_s.busy = 1'b1;
          nxt_s.hdr = (op_in == HOP_READ || op_in == HOP_WRITE) ? HDR_ADDR : 2'h0;
          if (op_in == HOP_READ || op_in == HOP_WRITE) begin
            nxt_s.left = {1'b0, len_in} + 17'h0_0002;
          end else if (op_in == HOP_STAT) begin
            nxt_s.left = {1'b0, len_in};
          end else begin
            nxt_s.left = 17'h0_0000;
          end
          nxt_s.st = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (half && !s_ff.sck) begin
          // Sample on the rising edge, drive on the falling one
          nxt_s.sck = 1'b1;
          nxt_s.rx = {s_ff.rx[6:0], s_ff.so_s2};
        end else if (half) begin
          nxt_s.sck = 1'b0;
          nxt_s.bitc = s_ff.bitc + 3'h1;
          if (s_ff.bitc == 3'h7) begin
            if (s_ff.cur_data && s_ff.op != HOP_WRITE) begin
              nxt_s.rd_data = s_ff.rx;
              nxt_s.rd_valid = 1'b1;
            end
            if (s_ff.left == 17'h0_0000) begin
              // Select rises later in this same low phase
              nxt_s.st = HS_TAIL;
            end else begin
              nxt_s.left = s_ff.left - 17'h0_0001;
              if (s_ff.hdr == HDR_ADDR) begin
                nb = s_ff.addr[15:8];
              end else if (s_ff.hdr != 2'h0) begin
                nb = s_ff.addr[7:0];
              end else if (s_ff.op == HOP_WRITE) begin
                nb = wr_data_in;
                nxt_s.wr_take = 1'b1;
              end
              nxt_s.cur_data = s_ff.hdr == 2'h0;
              nxt_s.hdr = (s_ff.hdr == 2'h0) ? 2'h0 : s_ff.hdr - 2'h1;
              nxt_s.si = nb[7];
              nxt_s.tx = {nb[6:0], 1'b0};
            end
          end else begin
            nxt_s.si = s_ff.tx[7];
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
          end
        end
      end
      HS_TAIL: begin
        if (half) begin
          nxt_s.cs_n = 1'b1;
          nxt_s.st = HS_GAP;
        end
      end
      HS_GAP: begin
        // Deselected gap guarantees a new falling select edge
        if (half) begin
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = HS_IDLE;
        end
      end
      default: nxt_s = HOST_RST;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_ff <= HOST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.cs_n = s_ff.cs_n;
  assign link.sck = s_ff.sck;
  assign link.si = s_ff.si;
  assign rd_data_out = s_ff.rd_data;
  assign rd_valid_out = s_ff.rd_valid;
  assign wr_take_out = s_ff.wr_take;
  assign busy_out = s_ff.busy;
  assign done_out = s_ff.done;
endmodule : see_host

// [rtl/see_dev.sv]
`timescale 1ns/10ps
module see_dev
  import see_pkg::*;
#(
  parameter int PROG_CYCLES = WRITE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  see_link_if.dev link,
  input wire logic block_protect_low_bit_in,
  input wire logic block_protect_high_bit_in,
  output logic busy_out,
  output logic write_enabled_out
);
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];
  see_dev_s_t s_ff;
  see_dev_s_t nxt_s;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] in_byte;
  logic [7:0] op;
  logic [7:0] status;
  logic [ADDR_W-1:0] new_addr;
  logic [ADDR_W-1:0] mem_idx;
  logic mem_we;
  logic pb_we;
  logic [PAGE_W-1:0] pb_idx;

  function automatic logic protect(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'h1: hit = a[ADDR_W-1] & a[ADDR_W-2];
      2'h2: hit = a[ADDR_W-1];
      2'h3: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : protect

  always_comb begin
    nxt_s = s_ff;
    mem_we = 1'b0;
    pb_we = 1'b0;
    pb_idx = s_ff.addr[PAGE_W-1:0];
    mem_idx = {s_ff.addr[ADDR_W-1:PAGE_W], s_ff.wcnt[PAGE_W-1:0]};
    nxt_s.cs_s1 = link.cs_n;
    nxt_s.cs_s2 = s_ff.cs_s1;
    nxt_s.cs_q = s_ff.cs_s2;
    nxt_s.sck_s1 = link.sck;
    nxt_s.sck_s2 = s_ff.sck_s1;
    nxt_s.sck_q = s_ff.sck_s2;
    nxt_s.si_s1 = link.si;
    nxt_s.si_s2 = s_ff.si_s1;
    cs_fall = s_ff.cs_q & ~s_ff.cs_s2;
    cs_rise = ~s_ff.cs_q & s_ff.cs_s2;
    sck_rise = ~s_ff.sck_q & s_ff.sck_s2 & ~s_ff.cs_s2;
    sck_fall = s_ff.sck_q & ~s_ff.sck_s2 & ~s_ff.cs_s2;
    in_byte = {s_ff.sh[6:0], s_ff.si_s2};
    op = in_byte & CMD_MASK;
    new_addr = {s_ff.sh[ADDR_W-2:0], s_ff.si_s2};
    // All ones while busy, so bit 0 reads as one
    status = s_ff.busy ? STAT_BUSY : {4'h0, block_protect_high_bit_in,
                                      block_protect_low_bit_in, s_ff.wel, 1'b0};

    // Self-timed cycle: the first 32 cycles commit the page buffer
    if (s_ff.busy) begin
      nxt_s.wcnt = s_ff.wcnt + 32'h0000_0001;
      if (s_ff.wcnt < 32'(PAGE_BYTES)) begin
        mem_we = s_ff.pvalid[s_ff.wcnt[PAGE_W-1:0]] &
                 ~protect(mem_idx, {block_protect_high_bit_in, block_protect_low_bit_in});
      end
      if (s_ff.wcnt == 32'(PROG_CYCLES - 1)) begin
        nxt_s.busy = 1'b0;
        nxt_s.wel = 1'b0;
      end
    end

    if (s_ff.cs_s2) begin
      // Only a frame that ended right after a whole byte programs
      if (cs_rise && s_ff.st == DS_WDATA && s_ff.byte_ok && s_ff.wel && !s_ff.busy) begin
        nxt_s.busy = 1'b1;
        nxt_s.wcnt = 32'h0000_0000;
      end
      nxt_s.st = DS_IDLE;
      nxt_s.so_oe = 1'b0;
    end else if (cs_fall) begin
      nxt_s.st = DS_CMD;
      nxt_s.cnt = 4'h0;
      nxt_s.byte_ok = 1'b0;
      if (!s_ff.busy) begin
        nxt_s.pvalid = '0;
      end
    end else begin
      case (s_ff.st)
        DS_CMD: begin
          if (sck_rise) begin
            nxt_s.sh = {s_ff.sh[14:0], s_ff.si_s2};
            nxt_s.cnt = s_ff.cnt + 4'h1;
            if (s_ff.cnt == BYTE_LAST) begin
              nxt_s.cnt = 4'h0;
              nxt_s.st = DS_IGNORE;
              if (s_ff.busy && op != OP_STAT) begin
                nxt_s.st = DS_IGNORE;
              end else begin
                case (op)
                  OP_READ: begin
                    nxt_s.st = DS_ADDR;
                    nxt_s.is_rd = 1'b1;
                  end
                  OP_WRITE: begin
                    // Without the latch the frame is dropped until deselect
                    nxt_s.st = s_ff.wel ? DS_ADDR : DS_IGNORE;
                    nxt_s.is_rd = 1'b0;
                  end
                  OP_WR_ENABLE: nxt_s.wel = 1'b1;
                  OP_WRDI: nxt_s.wel = 1'b0;
                  OP_STAT: begin
                    nxt_s.st = DS_RDATA;
                    nxt_s.is_stat = 1'b1;
                    nxt_s.tx = status;
                    nxt_s.so_oe = 1'b1;
                  end
                  default: nxt_s.st = DS_IGNORE;
                endcase
              end
            end
          end
        end
        DS_ADDR: begin
          if (sck_rise) begin
            nxt_s.sh = {s_ff.sh[14:0], s_ff.si_s2};
            nxt_s.cnt = s_ff.cnt + 4'h1;
            if (s_ff.cnt == ADDR_LAST) begin
              nxt_s.cnt = 4'h0;
              nxt_s.addr = new_addr;
              if (s_ff.is_rd) begin
                nxt_s.st = DS_RDATA;
                nxt_s.is_stat = 1'b0;
                nxt_s.tx = mem[new_addr];
                nxt_s.addr = new_addr + 13'h0001;
                nxt_s.so_oe = 1'b1;
              end else begin
                nxt_s.st = DS_WDATA;
              end
            end
          end
        end
        DS_RDATA: begin
          // Input is not looked at here; output moves on falling edges
          if (sck_fall) begin
            nxt_s.so = s_ff.tx[7];
            nxt_s.cnt = s_ff.cnt + 4'h1;
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
            if (s_ff.cnt == BYTE_LAST) begin
              nxt_s.cnt = 4'h0;
              if (s_ff.is_stat) begin
                nxt_s.tx = status;
              end else begin
                nxt_s.tx = mem[s_ff.addr];
                nxt_s.addr = s_ff.addr + 13'h0001;
              end
            end
          end
        end
        DS_WDATA: begin
          if (sck_rise) begin
            nxt_s.sh = {s_ff.sh[14:0], s_ff.si_s2};
            nxt_s.cnt = s_ff.cnt + 4'h1;
            nxt_s.byte_ok = 1'b0;
            if (s_ff.cnt == BYTE_LAST) begin
              nxt_s.cnt = 4'h0;
              nxt_s.byte_ok = 1'b1;
              pb_we = 1'b1;
              nxt_s.pvalid[pb_idx] = 1'b1;
              // Upper bits stay on the page
              nxt_s.addr[PAGE_W-1:0] = s_ff.addr[PAGE_W-1:0] + 5'h01;
            end
          end
        end
        DS_IGNORE: nxt_s.st = DS_IGNORE;
        DS_IDLE: nxt_s.st = DS_IDLE;
        default: nxt_s.st = DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_ff <= DEV_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Array and page buffer carry no reset, like the cells they model
  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      mem[mem_idx] <= pbuf[s_ff.wcnt[PAGE_W-1:0]];
    end
    if (pb_we) begin
      pbuf[pb_idx] <= in_byte;
    end
  end

  assign link.so = s_ff.so;
  assign link.so_oe = s_ff.so_oe;
  assign busy_out = s_ff.busy;
  assign write_enabled_out = s_ff.wel;
endmodule : see_dev

// [tb/see_props.sv]
`timescale 1ns/10ps
module see_props #(
  parameter int PROG_CYCLES = 64
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy_out,
  input wire logic write_enabled_out
);
  int bcnt_ff;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Length of the self-timed cycle, too long for a repetition
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !busy_out) bcnt_ff <= 0;
    else bcnt_ff <= bcnt_ff + 1;
  end
  sequence s_prog_start;
    $rose(busy_out);
  endsequence
  sequence s_prog_end;
    $fell(busy_out);
  endsequence
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  AST_SI_CHANGE: assert property ($changed(si) |-> !sck)
    else $error("si moved while sck high");
  AST_SO_CHANGE: assert property ($changed(so) |-> !sck)
    else $error("so moved while sck high");
  AST_CS_FALL: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("sck rose too soon after select");
  AST_OE_FRAME: assert property ($rose(so_oe) |-> !cs_n)
    else $error("so driven outside a frame");
  AST_OE_DROP: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
    else $error("so still driven after deselect");
  AST_PROG_START: assert property (s_prog_start |-> cs_n && $past(write_enabled_out))
    else $error("programming without latch or inside frame");
  AST_PROG_LEN: assert property (s_prog_end |->
    bcnt_ff >= PROG_CYCLES - 2 && bcnt_ff <= PROG_CYCLES + 2)
    else $error("programming length wrong");
  AST_WEL_CLEAR: assert property (s_prog_end |-> !write_enabled_out)
    else $error("latch not cleared at programming end");
  AST_BUSY_LOCK: assert property (busy_out && $past(busy_out) |-> !$fell(write_enabled_out))
    else $error("latch changed by command while busy");
endmodule : see_props

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import see_pkg::*;
  localparam int PROG = 1500;
  logic core_clk, rst_n, h_req, h_rv, h_take, h_busy, h_done;
  logic d_busy, d_wel, d2_busy, d2_wel;
  see_host_op_t h_op;
  logic [15:0] h_addr, h_len, a;
  logic [7:0] h_wd, h_rd, q2;
  logic [1:0] bp;
  logic [12:0] x;
  logic [7:0] wbuf [0:63];
  logic [7:0] rbuf [0:63];
  logic [7:0] mem [0:8191];
  bit known [0:8191];
  int err_total, comparisons, seed, n;
  see_link_if l1 ();
  see_link_if l2 ();
  see_host see_host_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .link(l1), .req_in(h_req),
    .op_in(h_op), .addr_in(h_addr), .len_in(h_len), .wr_data_in(h_wd), .rd_data_out(h_rd),
    .rd_valid_out(h_rv), .wr_take_out(h_take), .busy_out(h_busy), .done_out(h_done));
  see_dev #(.PROG_CYCLES(PROG)) see_dev_i (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .link(l1), .block_protect_low_bit_in(bp[0]), .block_protect_high_bit_in(bp[1]),
    .busy_out(d_busy), .write_enabled_out(d_wel));
  // Bench-driven end, used to break the host's side of the rules
  see_dev #(.PROG_CYCLES(PROG)) see_dev_i2 (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .link(l2), .block_protect_low_bit_in(1'b0), .block_protect_high_bit_in(1'b0),
    .busy_out(d2_busy), .write_enabled_out(d2_wel));
  see_props #(.PROG_CYCLES(PROG)) see_props_i (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .cs_n(l1.cs_n), .sck(l1.sck), .si(l1.si), .so(l1.so), .so_oe(l1.so_oe),
    .busy_out(d_busy), .write_enabled_out(d_wel));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wait_c(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : wait_c
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  function automatic bit prot(input logic [12:0] y, input logic [1:0] b);
    return (b == 2'h3) || (b == 2'h2 && y[12]) || (b == 2'h1 && y[12:11] == 2'h3);
  endfunction : prot
  task automatic op(input see_host_op_t o, input logic [15:0] ad, input int len);
    int k;
    k = 0;
    h_op = o;
    h_addr = ad;
    h_len = 16'(len);
    h_wd = wbuf[0];
    h_req = 1'b1;
    wait_c(1);
    h_req = 1'b0;
    for (int t = 0; t < 30000; t++) begin
      if (h_done) break;
      if (h_rv) rbuf[k] = h_rd;
      if (h_take) h_wd = wbuf[k + 1];
      if (h_rv || h_take) k++;
      wait_c(1);
    end
    chk(h_done, 1'b1);
    chk(h_busy, 1'b0);
    chk(8'(k), 8'(len));
  endtask : op
  task automatic rd(input logic [15:0] ad, input int len);
    logic [12:0] y;
    op(HOP_READ, ad, len);
    for (int i = 0; i < len; i++) begin
      y = ad[12:0] + 13'(i);
      if (known[y]) chk(rbuf[i], mem[y]);
    end
  endtask : rd
  task automatic poll();
    for (int i = 0; i < 50; i++) begin
      op(HOP_STAT, '0, 1);
      if (rbuf[0][0] === 1'b0) break;
    end
    chk(d_busy, 1'b0);
  endtask : poll
  // Far end by hand: sck at 80 ns, so sampled late in the high phase
  task automatic fr(input logic [31:0] w, input int nb);
    l2.cs_n = 1'b0;
    wait_c(4);
    for (int i = 31; i > 31 - nb; i--) begin
      l2.si = w[i];
      wait_c(4);
      l2.sck = 1'b1;
      wait_c(4);
      q2 = {q2[6:0], l2.so};
      l2.sck = 1'b0;
    end
    wait_c(2);
    l2.cs_n = 1'b1;
    wait_c(8);
  endtask : fr
  initial begin
    #900_000;
    err_total++;
    finish_test();
  end
  initial begin
    seed = 25;
    err_total = 0;
    comparisons = 0;
    {h_req, h_addr, h_len, h_wd, bp, q2} = '0;
    h_op = HOP_WR_ENABLE;
    l2.cs_n = 1'b1;
    l2.sck = 1'b0;
    l2.si = 1'b0;
    rst_n = 1'b0;
    wait_c(20);
    rst_n = 1'b1;
    wait_c(4);
    op(HOP_STAT, '0, 1);
    chk(rbuf[0], 8'h00);
    for (int j = 0; j < 4; j++) begin
      a = (j == 1) ? 16'h1FE0 : (j == 2) ? 16'h0000 : (j == 3) ? 16'h0001 : 16'($random(seed));
      n = (j == 0) ? 34 : (j == 2) ? 5 : 32;
      bp = (j == 3) ? 2'h3 : 2'h0;
      op(HOP_WR_ENABLE, '0, 0);
      op(HOP_STAT, '0, 1);
      chk(rbuf[0], {4'h0, bp, 2'h2});
      for (int i = 0; i < n; i++) wbuf[i] = 8'($random(seed));
      op(HOP_WRITE, a, n);
      if (j < 3) begin
        op(HOP_STAT, '0, 1);
        chk(rbuf[0], STAT_BUSY);
        op(HOP_WRDI, '0, 0);
        chk(d_wel, 1'b1);
      end
      poll();
      chk(d_wel, 1'b0);
      for (int i = 0; i < n; i++) begin
        x = {a[12:5], a[4:0] + 5'(i)};
        if (!prot(x, bp)) begin
          mem[x] = wbuf[i];
          known[x] = 1'b1;
        end
      end
      rd({a[15:5], 5'h00}, 32);
    end
    bp = 2'h0;
    rd(16'hFFFE, 4);
    op(HOP_WRITE, 16'h0000, 2);
    wait_c(30);
    chk(d_busy, 1'b0);
    rd(16'h0000, 5);
    rd(16'h0002, 1);
    fr(32'h0E00_0000, 8);
    chk(d2_wel, 1'b1);
    fr(32'h0A00_40A5, 28);
    chk(d2_busy, 1'b0);
    fr(32'h0A00_40A5, 32);
    chk(d2_busy, 1'b1);
    wait_c(PROG + 20);
    // Nonzero top nibble must not pass for an enable
    fr(32'h8600_0000, 8);
    chk(d2_wel, 1'b0);
    fr(32'h0B00_4000, 32);
    chk(q2, 8'hA5);
    finish_test();
  end
endmodule : tb_top
